// ==== src/sew_pkg.sv ====
package sew_pkg;

   // slave address layout
   localparam logic [3:0] TYPE_PAT = 4'ha;
   localparam int TYPE_MSB = 7;
   localparam int TYPE_LSB = 4;
   localparam int SEL_MSB = 3;
   localparam int SEL_LSB = 1;
   localparam int DIR_BIT = 0;
   localparam logic DIR_READ = 1'b1;

   // array and page geometry
   localparam int ADDR_W = 11;
   localparam int PAGE_BYTES = 16;
   localparam logic [4:0] DRAIN_DONE = 5'h10;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam int EXT_BITS_DFLT = 0;
   localparam int FIFO_DEPTH_DFLT = 8;
   localparam int FIFO_W = ADDR_W + 8;

   // timing at a 10 MHz core clock
   localparam int CLK_KHZ = 10000;
   localparam real PU_TIME_MS = 0.35;
   localparam int PU_CYCLES = int'($floor(PU_TIME_MS * CLK_KHZ));
   localparam int PU_CW = 12;
   localparam real WR_TIME_MS = 4.0;
   localparam int WR_CYCLES_DFLT = int'($floor(WR_TIME_MS * CLK_KHZ));

   // values after reset
   localparam logic SDA_RELEASED = 1'b0;
   localparam logic SDA_LOW_LEVEL = 1'b0;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_DEV = 3'h1,
      S_WORD = 3'h3,
      S_DATA = 3'h2,
      S_READ = 3'h6,
      S_IGNORE = 3'h7
   } sew_state_t;

endpackage

// ==== src/sew_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module sew_fifo #(
   parameter int WIDTH = sew_pkg::FIFO_W,
   parameter int DEPTH = sew_pkg::FIFO_DEPTH_DFLT
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   import sew_pkg::*;

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0] count;
   } sew_fifo_t;

   sew_fifo_t q_ff;
   sew_fifo_t nxt_q;
   logic push;
   logic pop;

   // depth need not be a power of two, so pointers wrap explicitly
   function automatic logic [AW-1:0] ptrInc(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   assign inReady = q_ff.count != (AW + 1)'(DEPTH);
   assign outValid = q_ff.count != '0;
   assign outData = q_ff.mem[q_ff.rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb begin
      nxt_q = q_ff;
      if (push) begin
         nxt_q.mem[q_ff.wrPtr] = inData;
         nxt_q.wrPtr = ptrInc(q_ff.wrPtr);
      end
      if (pop) begin
         nxt_q.rdPtr = ptrInc(q_ff.rdPtr);
      end
      nxt_q.count = q_ff.count + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

endmodule
`default_nettype wire

// ==== src/sew_slave.sv ====
// Function
// - supply up: come up idle, wait START
// - supply down: reset, drop any transaction
// - ignore bus until power-up delay done
// - sample on SCL rise, drive on fall, open-drain
// - undriven select and protect pins read low; the logic has no pull-down and relies on board pull-downs
// - protect pin high at word-address ack blocks data bytes
// - SDA change during SCL high is START/STOP
// - START is SDA fall, SCL high
// - STOP is SDA rise, SCL high, ends command
// - answer only device-type pattern 1010
// - address bit zero: one read, zero write
// - select bits match pins or carry address
// - acknowledge matching address in ninth clock
// - acknowledge word address and data bytes
// - read: release ninth clock, continue on ack
// - byte write commits at STOP
// - busy: line released, requests ignored
// - page write up to sixteen bytes, one cycle
// - only four low pointer bits increment
// - over sixteen bytes wraps within page
// - polling: no ack busy, ack when done
`timescale 1ns/1ps
`default_nettype none
module sew_slave #(
   parameter int EXT_BITS = sew_pkg::EXT_BITS_DFLT,
   parameter int WR_CYCLES = sew_pkg::WR_CYCLES_DFLT,
   parameter int FIFO_DEPTH = sew_pkg::FIFO_DEPTH_DFLT
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclPin,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic deviceSelectPin0,
   input wire logic deviceSelectPin1,
   input wire logic deviceSelectPin2,
   input wire logic writeProtectPin,
   output logic standbyReady,
   output logic writeBusy,
   output logic memWrValid,
   input wire logic memWrReady,
   output logic [sew_pkg::ADDR_W-1:0] memWrAddr,
   output logic [7:0] memWrData
);
   import sew_pkg::*;

   localparam int TW = $clog2(WR_CYCLES + 1);

   typedef struct packed {
      logic [2:0] scl;
      logic [2:0] sda;
      logic [3:0] pinMeta;
      logic [3:0] pinSync;
      sew_state_t state;
      sew_state_t after;
      logic [3:0] bitCnt;
      logic ackPh;
      logic [7:0] shift;
      logic mAck;
      logic [ADDR_W-1:0] ptr;
      logic wpLat;
      logic [PAGE_BYTES-1:0] pend;
      logic [PAGE_BYTES-1:0][7:0] page;
      logic busy;
      logic [TW-1:0] timer;
      logic [4:0] drainIdx;
      logic [PU_CW-1:0] puCnt;
      logic pwrDone;
      logic sdaOe;
      logic sdaOut;
   } sew_slave_t;

   sew_slave_t q_ff;
   sew_slave_t nxt_q;
   logic sclRise;
   logic sclFall;
   logic startDet;
   logic stopDet;
   logic decide;
   logic finish;
   logic selOk;
   logic pushValid;
   logic fifoInReady;
   logic [FIFO_W-1:0] pushData;
   logic [FIFO_W-1:0] popData;

   // select bits below EXT_BITS are array address, the rest must match
   function automatic logic selMatch(input logic [2:0] got,
                                     input logic [2:0] pins);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 3; i++) begin
         if (i >= EXT_BITS && got[i] != pins[i]) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   function automatic logic [2:0] pageHigh(input logic [2:0] got);
      logic [2:0] h;
      h = '0;
      for (int i = 0; i < 3; i++) begin
         if (i < EXT_BITS) begin
            h[i] = got[i];
         end
      end
      return h;
   endfunction

   // edges are taken from the second and third stages only
   assign sclRise = q_ff.scl[1] && !q_ff.scl[2];
   assign sclFall = !q_ff.scl[1] && q_ff.scl[2];
   assign startDet = q_ff.scl[1] && q_ff.scl[2] &&
                     !q_ff.sda[1] && q_ff.sda[2];
   assign stopDet = q_ff.scl[1] && q_ff.scl[2] &&
                    q_ff.sda[1] && !q_ff.sda[2];
   assign decide = sclFall && q_ff.bitCnt == ACK_SLOT && !q_ff.ackPh;
   assign finish = sclFall && q_ff.ackPh;
   assign selOk = selMatch(q_ff.shift[SEL_MSB:SEL_LSB], q_ff.pinSync[2:0]);
   assign pushData = {q_ff.ptr[ADDR_W-1:4], q_ff.drainIdx[3:0],
                      q_ff.page[q_ff.drainIdx[3:0]]};

   always_comb begin
      nxt_q = q_ff;
      pushValid = 1'b0;
      nxt_q.scl = {q_ff.scl[1:0], sclPin};
      nxt_q.sda = {q_ff.sda[1:0], sdaIn};
      // pins pulled low on the board when undriven; logic sees plain 0
      nxt_q.pinMeta = {writeProtectPin, deviceSelectPin2,
                       deviceSelectPin1, deviceSelectPin0};
      nxt_q.pinSync = q_ff.pinMeta;

      if (!q_ff.pwrDone) begin
         if (q_ff.puCnt == PU_CW'(PU_CYCLES - 1)) begin
            nxt_q.pwrDone = 1'b1;
         end else begin
            nxt_q.puCnt = q_ff.puCnt + PU_CW'(1);
         end
      end

      // internal write: hold busy for the full time and until drained
      if (q_ff.busy) begin
         if (q_ff.timer != '0) begin
            nxt_q.timer = q_ff.timer - TW'(1);
         end
         if (q_ff.drainIdx != DRAIN_DONE) begin
            pushValid = q_ff.pend[q_ff.drainIdx[3:0]];
            if (!pushValid || fifoInReady) begin
               nxt_q.pend[q_ff.drainIdx[3:0]] = 1'b0;
               nxt_q.drainIdx = q_ff.drainIdx + 5'h1;
            end
         end else if (q_ff.timer == '0) begin
            nxt_q.busy = 1'b0;
         end
      end

      if (!q_ff.pwrDone) begin
         nxt_q.state = S_IDLE;
         nxt_q.sdaOe = SDA_RELEASED;
      end else if (startDet) begin
         nxt_q.state = S_DEV;
         nxt_q.bitCnt = '0;
         nxt_q.ackPh = 1'b0;
         nxt_q.sdaOe = SDA_RELEASED;
         if (!q_ff.busy) begin
            // a restart without STOP abandons the unwritten page
            nxt_q.pend = '0;
         end
      end else if (stopDet) begin
         nxt_q.state = S_IDLE;
         nxt_q.ackPh = 1'b0;
         nxt_q.sdaOe = SDA_RELEASED;
         if (q_ff.state == S_DATA && q_ff.pend != '0 && !q_ff.busy) begin
            nxt_q.busy = 1'b1;
            nxt_q.timer = TW'(WR_CYCLES - 1);
            nxt_q.drainIdx = '0;
         end
      end else if (q_ff.state != S_IDLE && q_ff.state != S_IGNORE) begin
         if (sclRise && !q_ff.ackPh && q_ff.bitCnt != ACK_SLOT) begin
            nxt_q.shift = {q_ff.shift[6:0], q_ff.sda[1]};
            nxt_q.bitCnt = q_ff.bitCnt + 4'h1;
         end
         if (sclRise && q_ff.ackPh) begin
            nxt_q.mAck = !q_ff.sda[1];
         end
         if (decide) begin
            nxt_q.ackPh = 1'b1;
            nxt_q.sdaOe = SDA_RELEASED;
            nxt_q.after = S_IGNORE;
            case (q_ff.state)
               S_DEV: begin
                  if (q_ff.shift[TYPE_MSB:TYPE_LSB] == TYPE_PAT && selOk &&
                      !q_ff.busy) begin
                     nxt_q.sdaOe = 1'b1;
                     nxt_q.ptr[ADDR_W-1:8] =
                        pageHigh(q_ff.shift[SEL_MSB:SEL_LSB]);
                     nxt_q.after = (q_ff.shift[DIR_BIT] == DIR_READ) ?
                                   S_READ : S_WORD;
                  end
               end
               S_WORD: begin
                  nxt_q.sdaOe = 1'b1;
                  nxt_q.ptr[7:0] = q_ff.shift;
                  nxt_q.after = S_DATA;
               end
               S_DATA: begin
                  if (!q_ff.wpLat) begin
                     nxt_q.sdaOe = 1'b1;
                     nxt_q.page[q_ff.ptr[3:0]] = q_ff.shift;
                     nxt_q.pend[q_ff.ptr[3:0]] = 1'b1;
                     nxt_q.ptr[3:0] = q_ff.ptr[3:0] + 4'h1;
                     nxt_q.after = S_DATA;
                  end
               end
               S_READ: begin
                  // read data path lives elsewhere; line stays released
                  nxt_q.after = S_READ;
               end
               default: begin
                  nxt_q.after = S_IGNORE;
               end
            endcase
         end
         if (finish) begin
            nxt_q.ackPh = 1'b0;
            nxt_q.sdaOe = SDA_RELEASED;
            nxt_q.bitCnt = '0;
            nxt_q.state = q_ff.after;
            if (q_ff.state == S_WORD) begin
               // protect level taken on the fall before the first data byte
               nxt_q.wpLat = q_ff.pinSync[3];
            end
            if (q_ff.state == S_READ && !q_ff.mAck) begin
               nxt_q.state = S_IGNORE;
            end
         end
      end
   end

   // a synchronous reset stands for the supply trip: all state is dropped
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q_ff <= '0;
         q_ff.scl <= 3'h7;
         q_ff.sda <= 3'h7;
         q_ff.state <= S_IDLE;
         q_ff.after <= S_IDLE;
         q_ff.drainIdx <= DRAIN_DONE;
         q_ff.sdaOut <= SDA_LOW_LEVEL;
      end else begin
         q_ff <= nxt_q;
      end
   end

   sew_fifo #(
      .WIDTH(FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .inValid(pushValid),
      .inReady(fifoInReady),
      .inData(pushData),
      .outValid(memWrValid),
      .outReady(memWrReady),
      .outData(popData)
   );

   assign memWrAddr = popData[FIFO_W-1:8];
   assign memWrData = popData[7:0];
   // open drain: the driven level is always low
   assign sdaOut = q_ff.sdaOut;
   assign sdaOe = q_ff.sdaOe;
   assign standbyReady = q_ff.pwrDone;
   assign writeBusy = q_ff.busy;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence devDecide;
      decide && q_ff.state == S_DEV && q_ff.pwrDone;
   endsequence

   sequence dataDecide;
      decide && q_ff.state == S_DATA && q_ff.pwrDone;
   endsequence

   a_od_level: assert property (q_ff.sdaOe |-> !q_ff.sdaOut)
      else $error("data line driven high");
   a_type_gate: assert property (
      devDecide ##0 q_ff.shift[TYPE_MSB:TYPE_LSB] != TYPE_PAT |=> !q_ff.sdaOe)
      else $error("foreign device type acknowledged");
   a_addr_ack: assert property (
      devDecide ##0 (q_ff.shift[TYPE_MSB:TYPE_LSB] == TYPE_PAT && selOk &&
      !q_ff.busy) |=> q_ff.sdaOe && q_ff.ackPh)
      else $error("matching address not acknowledged");
   a_poll_nack: assert property (
      devDecide ##0 q_ff.busy |=> !q_ff.sdaOe)
      else $error("acknowledge while write cycle runs");
   a_ack_release: assert property (finish |=> !q_ff.sdaOe)
      else $error("data line held past ninth clock");
   a_busy_quiet: assert property (q_ff.busy |-> !q_ff.sdaOe)
      else $error("data line driven while busy");
   a_stop_commit: assert property (
      stopDet && q_ff.pwrDone && q_ff.state == S_DATA && q_ff.pend != '0 &&
      !q_ff.busy |=> q_ff.busy && q_ff.drainIdx == '0)
      else $error("stop did not start write cycle");
   a_page_wrap: assert property (
      dataDecide ##0 !q_ff.wpLat |=>
      q_ff.ptr[3:0] == $past(q_ff.ptr[3:0]) + 4'h1 &&
      q_ff.ptr[ADDR_W-1:4] == $past(q_ff.ptr[ADDR_W-1:4]))
      else $error("pointer left its page");
   a_wp_block: assert property (
      dataDecide ##0 q_ff.wpLat |=> !q_ff.sdaOe &&
      q_ff.pend == $past(q_ff.pend) && q_ff.after == S_IGNORE)
      else $error("protected write accepted");
   a_start_seen: assert property (
      startDet && q_ff.pwrDone |=> q_ff.state == S_DEV && q_ff.bitCnt == '0)
      else $error("start not taken");
   a_stop_end: assert property (stopDet |=> q_ff.state == S_IDLE)
      else $error("stop did not end command");
   a_powerup_quiet: assert property (
      !q_ff.pwrDone |-> q_ff.state == S_IDLE && !q_ff.sdaOe)
      else $error("bus served before power-up delay");
   a_reset_standby: assert property (
      $rose(rst_n) |-> q_ff.state == S_IDLE && !q_ff.busy && !q_ff.sdaOe
      ##1 !q_ff.pwrDone [*2])
      else $error("not in standby after reset");

endmodule
`default_nettype wire

// ==== verif/sew_i2c_master.sv ====
`timescale 1ns/1ps
`default_nettype none
// behavioural bus master; sclOut idles high between frames
module sew_i2c_master (
   input wire logic clk,
   output logic sclOut,
   output logic sdaPull,
   input wire logic sdaWire
);
   initial begin
      sclOut = 1'b1;
      sdaPull = 1'b0;
   end
   // quarter of an 800 ns bus period
   task automatic q();
      repeat (2) @(posedge clk);
      #1;
   endtask
   // also serves as repeated start: line released while clock low
   task automatic start();
      sdaPull = 1'b0;
      q();
      sclOut = 1'b1;
      q();
      sdaPull = 1'b1;
      q();
      sclOut = 1'b0;
      q();
   endtask
   task automatic stop();
      sdaPull = 1'b1;
      q();
      sclOut = 1'b1;
      q();
      sdaPull = 1'b0;
      q();
      q();
   endtask
   // data changes only while the clock is low
   task automatic bitCycle(input logic b, output logic r);
      sdaPull = !b;
      q();
      sclOut = 1'b1;
      q();
      r = sdaWire;
      q();
      sclOut = 1'b0;
      q();
   endtask
   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitCycle(d[i], r);
      end
      bitCycle(1'b1, r);
      ack = !r;
   endtask
   // nack on the last byte ends a read session
   task automatic recvByte(input logic ackIt, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitCycle(1'b1, r);
         d[i] = r;
      end
      bitCycle(!ackIt, r);
   endtask
endmodule
`default_nettype wire

// ==== verif/serial_eeprom_i2c_slave_write_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_i2c_slave_write_test;
   import sew_pkg::*;
   localparam int WRC = 200;
   logic clk, rst_n, scl, mPull, sdaOut, sdaOe, wp, ready, busy;
   logic memWrValid, memWrReady, a1, a2, a3;
   logic [ADDR_W-1:0] memWrAddr;
   logic [7:0] memWrData, d;
   logic [ADDR_W+7:0] got[$];
   // time of the latest reset release; the power-up delay counts from it
   realtime tRel;
   wire logic sda;
   int error_cnt, total_checks;
   // open-drain wire: either party pulls it low
   assign sda = !(sdaOe | mPull);
   sew_i2c_master u_mst (.clk(clk), .sclOut(scl), .sdaPull(mPull),
      .sdaWire(sda));
   sew_slave #(.WR_CYCLES(WRC)) u_dut (.clk(clk), .rst_n(rst_n),
      .sclPin(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .deviceSelectPin0(1'b0), .deviceSelectPin1(1'b0),
      .deviceSelectPin2(1'b0), .writeProtectPin(wp),
      .standbyReady(ready), .writeBusy(busy), .memWrValid(memWrValid),
      .memWrReady(memWrReady), .memWrAddr(memWrAddr),
      .memWrData(memWrData));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      if (memWrValid === 1'b1 && memWrReady === 1'b1) begin
         got.push_back({memWrAddr, memWrData});
      end
   end
   task automatic check(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic head(input logic [7:0] dev, input logic [7:0] w);
      u_mst.start();
      u_mst.sendByte(dev, a1);
      u_mst.sendByte(w, a2);
   endtask
   task automatic poll(output logic ack);
      u_mst.start();
      u_mst.sendByte(8'ha0, ack);
      u_mst.stop();
   endtask
   // bounded wait, long enough for the write time plus drain
   task automatic waitIdle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      #1;
      check(n < 1000, "write cycle never ended");
   endtask
   task automatic powerUp(input logic early);
      int n;
      check(sdaOe === 1'b0 && busy === 1'b0, "state after reset");
      check(ready === 1'b0, "ready too soon");
      if (early) begin
         poll(a3);
         check(a3 === 1'b0, "acked before ready");
      end
      n = 0;
      while (ready !== 1'b1 && n < 5000) begin
         @(posedge clk);
         n++;
      end
      n = int'(($realtime - tRel) / 100.0);
      check(n >= PU_CYCLES && n <= PU_CYCLES + 8, "power-up delay");
      repeat (4) @(posedge clk);
      #1;
      $display("test power-up done");
   endtask
   task automatic testByte();
      head(8'ha0, 8'h23);
      u_mst.sendByte(8'h5a, a3);
      u_mst.stop();
      check(a1 === 1'b1, "address not acked");
      check(a2 === 1'b1 && a3 === 1'b1, "byte not acked");
      check(busy === 1'b1, "no write at stop");
      poll(a3);
      check(a3 === 1'b0, "acked while busy");
      waitIdle();
      poll(a3);
      check(a3 === 1'b1, "no ack after write");
      check(got.size() == 1, "byte count");
      check(got[0] === {11'h023, 8'h5a}, "byte content");
      got.delete();
      $display("test byte write done");
   endtask
   task automatic testPage();
      logic all;
      logic [7:0] e;
      all = 1'b1;
      memWrReady = 1'b0;
      head(8'ha0, 8'h3e);
      for (int k = 0; k < 18; k++) begin
         u_mst.sendByte(8'(k), a3);
         all = all & a3;
      end
      u_mst.stop();
      check(all === 1'b1, "page byte not acked");
      repeat (WRC + 200) @(posedge clk);
      #1;
      // stalled array: fifo full, busy must stretch
      check(busy === 1'b1 && memWrValid === 1'b1, "stall");
      check(got.size() == 0, "taken while stalled");
      memWrReady = 1'b1;
      waitIdle();
      // busy ends once the page is in the fifo, which still drains after
      repeat (FIFO_DEPTH_DFLT + 4) @(posedge clk);
      #1;
      check(memWrValid === 1'b0, "fifo not empty");
      check(got.size() == PAGE_BYTES, "page count");
      for (int i = 0; i < PAGE_BYTES && i < got.size(); i++) begin
         e = (i == 14) ? 8'h10 : (i == 15) ? 8'h11 : 8'(i + 2);
         check(got[i] === {11'h030 | 11'(i), e}, "page word");
      end
      got.delete();
      $display("test page write done");
   endtask
   task automatic testRefuse();
      logic [7:0] bad[5] = '{8'hb0, 8'ha2, 8'ha4, 8'ha8, 8'h20};
      u_mst.sendByte(8'ha0, a3);
      u_mst.stop();
      check(a3 === 1'b0, "acked without start");
      foreach (bad[i]) begin
         u_mst.start();
         u_mst.sendByte(bad[i], a3);
         u_mst.stop();
         check(a3 === 1'b0, "foreign address acked");
      end
      u_mst.start();
      u_mst.sendByte(8'ha1, a3);
      check(a3 === 1'b1, "read address not acked");
      u_mst.recvByte(1'b1, d);
      check(d === 8'hff, "line not released in read");
      u_mst.recvByte(1'b0, d);
      u_mst.stop();
      check(busy === 1'b0 && got.size() == 0, "read wrote");
      $display("test refusals done");
   endtask
   task automatic testProtect();
      wp = 1'b1;
      head(8'ha0, 8'h10);
      u_mst.sendByte(8'h77, a3);
      u_mst.stop();
      wp = 1'b0;
      check(a2 === 1'b1 && a3 === 1'b0, "protected data acked");
      repeat (8) @(posedge clk);
      #1;
      check(busy === 1'b0 && got.size() == 0, "protected write");
      $display("test protect done");
   endtask
   task automatic testBrownOut();
      head(8'ha0, 8'h50);
      fork
         u_mst.sendByte(8'h11, a3);
         begin
            repeat (20) @(posedge clk);
            #1;
            rst_n = 1'b0;
            repeat (2) @(posedge clk);
            #1;
            check(sdaOe === 1'b0, "line held in reset");
            rst_n = 1'b1;
            tRel = $realtime;
         end
      join
      u_mst.stop();
      powerUp(1'b0);
      check(busy === 1'b0 && got.size() == 0, "aborted write");
      $display("test brown-out done");
   endtask
   initial begin
      rst_n = 1'b0;
      wp = 1'b0;
      memWrReady = 1'b1;
      error_cnt = 0;
      total_checks = 0;
      repeat (16) @(posedge clk);
      #1;
      rst_n = 1'b1;
      tRel = $realtime;
      powerUp(1'b1);
      testByte();
      testPage();
      testRefuse();
      testProtect();
      testBrownOut();
      stop_test();
   end
   // all tests need about 10600 clocks
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      $display("mismatch at %0t: timeout", $time);
      stop_test();
   end
endmodule
`default_nettype wire
